// [core/io_decode_and_restart_vector.sv]
// Notes on behaviour
// R1 - serial controller only when A01 low
// R2 - A00 picks command/status or data register
// R3 - direction taken only from I/O strobes
// R4 - write decoder needs A01 high and write
// R5 - A07..A05 strobe one of seven ports
// R6 - fixed map of seven write-only addresses
// R7 - each read port gated by one line
// R8 - reads never strobe any write port
// R9 - request line follows any of three sources
// R10 - processor finishes instruction, then acknowledge fetch
// R11 - vector buffer drives bus during acknowledge
// R12 - bits 3,4,5 carry keyboard, receiver, vertical
// R13 - other bits high, released when inactive
// R14 - vector zero never produced by hardware
// R15 - store latch bit masks receiver request
// R16 - jumper adds transmit-empty on receiver bit
// R17 - selects and vector decoded without wait states
`timescale 1ns/1ns
`include "io_decode_consts.svh"

module io_decode_and_restart_vector #(
  parameter bit RX_MASK_BUILD = 1'b1
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  input  wire logic [7:0]                i_addr,
  input  wire logic                      i_io_rd_b,
  input  wire logic                      i_io_wr_b,
  input  wire logic                      i_int_ack,
  input  wire logic [7:0]                i_data,
  input  wire logic                      i_kbd_irq,
  input  wire logic                      i_rx_irq,
  input  wire logic                      i_vf_irq,
  input  wire logic                      i_tx_empty_irq,
  input  wire logic                      i_tx_empty_irq_jumper,
  output logic                           o_serial_sel,
  output logic                           o_serial_cmd_sel,
  output logic                           o_serial_rd,
  output logic                           o_serial_wr,
  output io_decode_pkg::wr_strobe_t      o_wr_strobe,
  output io_decode_pkg::rd_enable_t      o_rd_en,
  output logic                           o_interrupt_request_line,
  output logic [7:0]                     o_data,
  output logic                           o_data_oe,
  output logic                           o_receiver_irq_mask_bit
);

  function automatic io_decode_pkg::wr_strobe_t wr_decode(input logic [2:0] code);
    io_decode_pkg::wr_strobe_t s;
    s = '0;
    case (code)
      `WCODE_BAUD:     s[io_decode_pkg::WP_BAUD]     = 1'b1;
      `WCODE_BRIGHT:   s[io_decode_pkg::WP_BRIGHT]   = 1'b1;
      `WCODE_NVS:      s[io_decode_pkg::WP_NVS]      = 1'b1;
      `WCODE_KBD_TX:   s[io_decode_pkg::WP_KBD_TX]   = 1'b1;
      `WCODE_VIDEO_B:  s[io_decode_pkg::WP_VIDEO_B]  = 1'b1;
      `WCODE_VIDEO_A:  s[io_decode_pkg::WP_VIDEO_A]  = 1'b1;
      `WCODE_GRAPHICS: s[io_decode_pkg::WP_GRAPHICS] = 1'b1;
      default:         s = '0;
    endcase
    return s;
  endfunction

  // strobes and address
  wire logic       rd_act  = ~i_io_rd_b;
  wire logic       wr_act  = ~i_io_wr_b;
  wire logic       a01     = i_addr[`IO_A01_BIT];
  wire logic [2:0] wsel    = i_addr[`IO_WSEL_MSB:`IO_WSEL_LSB];

  // R1 serial region select
  wire logic serial_sel_nxt = ~a01 & (rd_act | wr_act);
  // R2 register choice by A00
  wire logic serial_cmd_nxt = serial_sel_nxt & i_addr[`IO_A00_BIT];
  // R3 direction from strobes; a read masks a stray write
  wire logic serial_rd_nxt  = ~a01 & rd_act;
  wire logic serial_wr_nxt  = ~a01 & wr_act & ~rd_act;

  // R4 R8 write decoder enable, held off during any read
  wire logic wdec_en = a01 & wr_act & ~rd_act;
  // R5 R6 one-hot port strobe
  wire io_decode_pkg::wr_strobe_t wr_strobe_nxt = wdec_en ? wr_decode(wsel) : '0;

  // R7 one address line per readable port
  wire logic rd_gate = a01 & rd_act;
  wire io_decode_pkg::rd_enable_t rd_en_nxt = rd_gate ?
    {i_addr[`IO_RD_KBD_BIT], i_addr[`IO_RD_FLAGS_BIT], i_addr[`IO_RD_MODEM_BIT]} : '0;

  // nonvolatile store latch, only the receiver mask bit is kept here
  logic nvs_mask_r;
  wire logic nvs_wr   = wr_strobe_nxt[io_decode_pkg::WP_NVS];
  wire logic nvs_mask_nxt = nvs_wr ? i_data[`NVS_RXMASK_BIT] : nvs_mask_r;

  // R15 mask only in the build that fits it
  wire logic rx_masked = RX_MASK_BUILD & nvs_mask_r;
  // R16 transmit-empty shares the receiver bit when jumpered
  wire logic rx_req = (i_rx_irq & ~rx_masked) | (i_tx_empty_irq & i_tx_empty_irq_jumper);

  // request field is frozen while acknowledge stands so a source dropping
  // mid-cycle cannot tear the opcode on the bus
  io_decode_pkg::ack_state_t ack_st_r;
  io_decode_pkg::ack_state_t ack_st_nxt;
  logic [2:0]                req_hold_r;
  logic [2:0]                req_hold_nxt;
  wire logic [2:0]           req_live = {i_vf_irq, rx_req, i_kbd_irq};

  always_comb begin
    ack_st_nxt   = ack_st_r;
    req_hold_nxt = req_hold_r;
    case (ack_st_r)
      io_decode_pkg::ACK_IDLE: begin
        req_hold_nxt = req_live;
        if (i_int_ack) begin
          ack_st_nxt = io_decode_pkg::ACK_ACTIVE;
        end
      end
      io_decode_pkg::ACK_ACTIVE: begin
        if (!i_int_ack) begin
          ack_st_nxt   = io_decode_pkg::ACK_IDLE;
          req_hold_nxt = req_live;
        end
      end
      default: begin
        ack_st_nxt   = io_decode_pkg::ACK_IDLE;
        req_hold_nxt = req_live;
      end
    endcase
  end

  // first acknowledge cycle uses the live pattern, later ones the frozen one
  wire logic [2:0] req_vec = (ack_st_r == io_decode_pkg::ACK_ACTIVE) ? req_hold_r : req_live;

  logic [7:0] opcode;
  logic       any_req;

  // R12 R13 opcode with request field
  restart_vector_gen u_vector (
    .i_kbd_req (req_vec[0]),
    .i_rx_req  (req_vec[1]),
    .i_vf_req  (req_vec[2]),
    .o_opcode  (opcode),
    .o_any_req (any_req)
  );

  // R11 R14 drive only on acknowledge with a request present; vector 00H
  // would restart the firmware, so an empty field leaves the bus alone
  wire logic vec_oe_nxt = i_int_ack & any_req;
  // R13 released lines read back as zero from this side
  wire logic [7:0] vec_data_nxt = vec_oe_nxt ? opcode : 8'h00;
  // R9 request gate
  wire logic irq_nxt = |req_live;

  // R17 one register stage, well inside any processor bus cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_serial_sel     <= 1'b0;
      o_serial_cmd_sel <= 1'b0;
      o_serial_rd      <= 1'b0;
      o_serial_wr      <= 1'b0;
      o_wr_strobe      <= '0;
      o_rd_en          <= '0;
    end else begin
      o_serial_sel     <= serial_sel_nxt;
      o_serial_cmd_sel <= serial_cmd_nxt;
      o_serial_rd      <= serial_rd_nxt;
      o_serial_wr      <= serial_wr_nxt;
      o_wr_strobe      <= wr_strobe_nxt;
      o_rd_en          <= rd_en_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_interrupt_request_line <= 1'b0;
      o_data                   <= 8'h00;
      o_data_oe                <= 1'b0;
      ack_st_r                 <= io_decode_pkg::ACK_IDLE;
      req_hold_r               <= 3'h0;
    end else begin
      o_interrupt_request_line <= irq_nxt;
      o_data                   <= vec_data_nxt;
      o_data_oe                <= vec_oe_nxt;
      ack_st_r                 <= ack_st_nxt;
      req_hold_r               <= req_hold_nxt;
    end
  end

  // R15 mask latched from data bus
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nvs_mask_r              <= `NVS_RXMASK_RST;
      o_receiver_irq_mask_bit <= `NVS_RXMASK_RST;
    end else begin
      nvs_mask_r              <= nvs_mask_nxt;
      o_receiver_irq_mask_bit <= nvs_mask_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // a read that overlaps a write wins, so serial_wr_a and wr_onehot_a (through wdec_en)
  // look at the read strobe as well as the write strobe

  serial_region_a: assert property ( // R1
    o_serial_sel |-> !$past(i_addr[`IO_A01_BIT]) && $past(rd_act || wr_act))
    else $error("serial controller selected outside its region");

  serial_reg_a: assert property ( // R2
    o_serial_sel |-> o_serial_cmd_sel == $past(i_addr[`IO_A00_BIT]))
    else $error("serial register choice does not follow A00");

  serial_dir_a: assert property ( // R3
    ##1 o_serial_rd == $past(!i_addr[`IO_A01_BIT] && !i_io_rd_b) && !(o_serial_rd && o_serial_wr))
    else $error("serial direction does not follow strobes");

  wdec_enable_a: assert property ( // R4
    (|o_wr_strobe) |-> $past(i_addr[`IO_A01_BIT] && !i_io_wr_b))
    else $error("write port strobed without A01 and write");

  wr_onehot_a: assert property ( // R5
    $onehot0(o_wr_strobe) and (($past(wdec_en) && ($past(wsel) != 3'h1)) |-> $onehot(o_wr_strobe)))
    else $error("write strobe not exactly one port");

  nvs_map_a: assert property ( // R6
    o_wr_strobe[io_decode_pkg::WP_NVS] |-> $past(i_addr[7:5]) == `WCODE_NVS)
    else $error("store latch strobed at wrong address");

  rd_gate_a: assert property ( // R7
    ##1 o_rd_en == ($past(rd_gate) ? $past(i_addr[7:5]) : 3'h0))
    else $error("read gate does not follow its address line");

  rd_no_wr_a: assert property ( // R8
    !i_io_rd_b |=> o_wr_strobe == '0)
    else $error("write port strobed during a read");

  irq_follow_a: assert property ( // R9
    (i_kbd_irq || i_vf_irq) |=> o_interrupt_request_line)
    else $error("request line missed a source");

  vec_drive_a: assert property ( // R11
    (i_int_ack && ack_st_r == io_decode_pkg::ACK_IDLE && (i_kbd_irq || i_vf_irq)) |=> o_data_oe)
    else $error("vector not driven during acknowledge");

  vec_fixed_a: assert property ( // R13
    o_data_oe |-> o_data[2:0] == 3'h7 && o_data[7:6] == 2'h3)
    else $error("fixed opcode bits not high");

  vec_release_a: assert property ( // R13
    !i_int_ack |=> !o_data_oe)
    else $error("vector buffer not released");

  vec_nonzero_a: assert property ( // R14
    o_data_oe |-> o_data[5:3] != 3'h0)
    else $error("restart zero produced");

  vec_field_a: assert property ( // R12
    (i_int_ack && ack_st_r == io_decode_pkg::ACK_IDLE && any_req) |=> o_data[5:3] == $past(req_live))
    else $error("request field wrong");

  rx_mask_a: assert property ( // R15
    (RX_MASK_BUILD && nvs_mask_r && !i_tx_empty_irq_jumper && !i_kbd_irq && !i_vf_irq) |=>
      !o_interrupt_request_line)
    else $error("masked receiver still raises request");

  tx_jumper_a: assert property ( // R16
    (i_tx_empty_irq && i_tx_empty_irq_jumper && i_int_ack && ack_st_r == io_decode_pkg::ACK_IDLE) |=>
      o_data[`VEC_RX_BIT])
    else $error("transmit-empty not on receiver bit");

  serial_wr_a: assert property ( // R3
    ##1 o_serial_wr == $past(!i_addr[`IO_A01_BIT] && !i_io_wr_b && i_io_rd_b))
    else $error("serial write does not follow strobes");

  serial_off_a: assert property ( // R1
    ((|o_wr_strobe) || (|o_rd_en)) |-> !o_serial_sel)
    else $error("serial controller selected with another port");

  baud_map_a: assert property ( // R6
    o_wr_strobe[io_decode_pkg::WP_BAUD] |-> $past(i_addr[7:5]) == `WCODE_BAUD)
    else $error("baud port strobed at wrong address");

  gfx_map_a: assert property ( // R6
    o_wr_strobe[io_decode_pkg::WP_GRAPHICS] |-> $past(i_addr[7:5]) == `WCODE_GRAPHICS)
    else $error("graphics port strobed at wrong address");

  rd_excl_a: assert property ( // R8
    (|o_rd_en) |-> o_wr_strobe == '0)
    else $error("read enable and write strobe together");

  irq_quiet_a: assert property ( // R9
    (!i_kbd_irq && !i_vf_irq && !i_rx_irq && !(i_tx_empty_irq && i_tx_empty_irq_jumper)) |=>
      !o_interrupt_request_line)
    else $error("request line raised with no source");

  vec_hold_a: assert property ( // R12
    (o_data_oe && i_int_ack && ack_st_r == io_decode_pkg::ACK_ACTIVE) |=> $stable(o_data))
    else $error("vector changed during acknowledge");

  serial_wr_c: cover property (o_serial_wr && o_serial_cmd_sel);
  flags_rd_c:  cover property (o_rd_en == 3'h2);
  vec_all_c:   cover property (o_data_oe && o_data == 8'hFF);
  nvs_wr_c:    cover property (o_wr_strobe[io_decode_pkg::WP_NVS] ##1 o_receiver_irq_mask_bit);
  vec_both_c:  cover property (i_int_ack ##1 o_data_oe && o_data == 8'hDF);

endmodule

// [pkg/io_decode_consts.svh]
`ifndef IO_DECODE_CONSTS_SVH
`define IO_DECODE_CONSTS_SVH

// address bit positions
`define IO_A00_BIT          0
`define IO_A01_BIT          1
`define IO_WSEL_LSB         5
`define IO_WSEL_MSB         7

// read gates: each readable port owns one address line
`define IO_RD_MODEM_BIT     5
`define IO_RD_FLAGS_BIT     6
`define IO_RD_KBD_BIT       7

// port offsets
`define OFS_SERIAL_DATA     8'h00
`define OFS_SERIAL_CMD      8'h01
`define OFS_BAUD_RATE       8'h02
`define OFS_MODEM_BUF       8'h22
`define OFS_BRIGHTNESS      8'h42
`define OFS_FLAGS_BUF       8'h42
`define OFS_NVS_LATCH       8'h62
`define OFS_KBD_TX          8'h82
`define OFS_KBD_RX          8'h82
`define OFS_VIDEO_B         8'hA2
`define OFS_VIDEO_A         8'hC2
`define OFS_GRAPHICS        8'hE2

// codes on address bits 7..5 for the write-only ports
`define WCODE_BAUD          3'h0
`define WCODE_BRIGHT        3'h2
`define WCODE_NVS           3'h3
`define WCODE_KBD_TX        3'h4
`define WCODE_VIDEO_B       3'h5
`define WCODE_VIDEO_A       3'h6
`define WCODE_GRAPHICS      3'h7

// restart opcode: fixed high bits, request field in bits 5..3
`define VEC_FIXED           8'hC7
`define VEC_KBD_BIT         3
`define VEC_RX_BIT          4
`define VEC_VF_BIT          5

// nonvolatile store latch bit that masks the receiver request
`define NVS_RXMASK_BIT      4
`define NVS_RXMASK_RST      1'h0

`endif

// [pkg/io_decode_pkg.sv]
package io_decode_pkg;

  // one strobe per write-only port, index order
  typedef enum logic [2:0] {
    WP_BAUD     = 3'h0,
    WP_BRIGHT   = 3'h1,
    WP_NVS      = 3'h2,
    WP_KBD_TX   = 3'h3,
    WP_VIDEO_B  = 3'h4,
    WP_VIDEO_A  = 3'h5,
    WP_GRAPHICS = 3'h6
  } wr_port_t;

  typedef logic [6:0] wr_strobe_t;
  typedef logic [2:0] rd_enable_t;

  typedef enum logic [1:0] {
    ACK_IDLE   = 2'b01,
    ACK_ACTIVE = 2'b10
  } ack_state_t;

endpackage

// [core/restart_vector_gen.sv]
`timescale 1ns/1ns
`include "io_decode_consts.svh"

module restart_vector_gen (
  input  wire logic       i_kbd_req,
  input  wire logic       i_rx_req,
  input  wire logic       i_vf_req,
  output logic [7:0]      o_opcode,
  output logic            o_any_req
);

  logic [7:0] field;

  assign field = {2'h0, i_vf_req, i_rx_req, i_kbd_req, 3'h0};
  // request field overrides nothing else: fixed bits are all ones outside it
  assign o_opcode  = `VEC_FIXED | field;
  assign o_any_req = i_kbd_req | i_rx_req | i_vf_req;

endmodule

// [bench/cpu_bus_model.sv]
`timescale 1ns/1ns
module cpu_bus_model (
  input  wire logic       i_clk,
  input  wire logic       i_irq,
  output logic [7:0]      o_addr,
  output logic            o_rd_b,
  output logic            o_wr_b,
  output logic            o_ack,
  output logic [7:0]      o_data
);
  initial begin
    o_addr = 8'h00;
    o_rd_b = 1'b1;
    o_wr_b = 1'b1;
    o_ack  = 1'b0;
    o_data = 8'h00;
  end

  // one strobe cycle; released data lines show the inverse, never a stale copy
  task automatic io_cycle(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_data <= d;
    o_wr_b <= ~wr;
    o_rd_b <= wr;
    @(posedge i_clk);
    o_wr_b <= 1'b1;
    o_rd_b <= 1'b1;
    o_data <= ~d;
  endtask

  task automatic int_ack(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge i_clk);
      ok = i_irq;
    end
    if (ok) begin
      o_ack <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_ack <= 1'b0;
    end
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ns
module tb;
  logic                       i_clk = 1'b0;
  logic                       rst_b = 1'b0;
  logic [7:0]                 addr, wdata, data, e_data;
  logic                       rd_b, wr_b, ack, ssel, scmd, srd, swr, irq, oe, mskb;
  logic                       kbd = 1'b0, rx = 1'b0, vf = 1'b0, tx = 1'b0, jmp = 1'b0;
  logic                       rnd_on = 1'b0;
  io_decode_pkg::wr_strobe_t  ws;
  io_decode_pkg::rd_enable_t  re;
  logic [7:0]                 r = 8'h44, s = 8'h44;
  logic [1:0]                 op;
  int                         miscompares = 0, n_tests = 0;
  bit                         ok;
  logic                       e_srd, e_swr, e_sel, e_cmd, care, e_irq, e_oe, msk, ackp;
  logic [6:0]                 e_ws;
  logic [2:0]                 e_re, fld, live;
  logic [7:0]                 tbl [10] = '{8'h02, 8'h22, 8'h42, 8'h62, 8'h82, 8'hA2, 8'hC2, 8'hE2, 8'h00, 8'h01};

  always #2 i_clk = ~i_clk;

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  cpu_bus_model i_cpu_bus_model (.i_clk(i_clk), .i_irq(irq), .o_addr(addr), .o_rd_b(rd_b),
    .o_wr_b(wr_b), .o_ack(ack), .o_data(wdata));

  io_decode_and_restart_vector i_io_decode_and_restart_vector (
    .i_clk(i_clk), .i_rst_b(rst_b), .i_addr(addr), .i_io_rd_b(rd_b), .i_io_wr_b(wr_b),
    .i_int_ack(ack), .i_data(wdata), .i_kbd_irq(kbd), .i_rx_irq(rx), .i_vf_irq(vf),
    .i_tx_empty_irq(tx), .i_tx_empty_irq_jumper(jmp), .o_serial_sel(ssel), .o_serial_cmd_sel(scmd),
    .o_serial_rd(srd), .o_serial_wr(swr), .o_wr_strobe(ws), .o_rd_en(re),
    .o_interrupt_request_line(irq), .o_data(data), .o_data_oe(oe), .o_receiver_irq_mask_bit(mskb));

  always @(posedge i_clk) begin
    if (rnd_on) begin
      {tx, vf, rx, kbd} <= s[3:0];
      s <= lfsr(s);
    end
  end

  // bench model: reads inputs as the design samples them, results checked at the next falling edge
  always @(posedge i_clk) begin
    live = {vf, (rx & ~msk) | (tx & jmp), kbd};
    if (!rst_b) begin
      {e_srd, e_swr, e_sel, e_cmd, care, e_irq, e_oe, msk, ackp} = 9'h000;
      e_ws = 7'h00;
      e_re = 3'h0;
      e_data = 8'h00;
    end else begin
      care = ~rd_b | ~wr_b;
      e_sel = ~addr[1] & care;
      e_cmd = addr[0];
      e_srd = ~rd_b & ~addr[1];
      e_swr = ~wr_b & rd_b & ~addr[1];
      e_re = (~rd_b & addr[1]) ? addr[7:5] : 3'h0;
      e_ws = (~wr_b & rd_b & addr[1] & (addr[7:5] != 3'h1)) ? 7'h01 << (addr[7:5] - (addr[7:5] != 3'h0)) : 7'h00;
      e_irq = |live;
      if (~wr_b & rd_b & addr[1] & (addr[7:5] == 3'h3)) msk = wdata[4];
      if (ack & ~ackp) fld = live;
      e_oe = ack & (fld != 3'h0);
      e_data = e_oe ? (8'hC7 | {2'h0, fld, 3'h0}) : 8'h00;
      ackp = ack;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  always @(negedge i_clk) begin
    if (!rst_b) begin
      chk("reset_outputs", 8'h00, data | {ws, 1'b0} | {re, ssel, scmd, srd, swr, irq} | {oe, mskb, 6'h00});
    end else begin
      chk("serial_rw", {6'h00, e_srd, e_swr}, {6'h00, srd, swr});
      chk("serial_sel", {7'h00, e_sel}, {7'h00, ssel});
      if (care & e_sel) chk("serial_cmd", {7'h00, e_cmd}, {7'h00, scmd});
      chk("wr_strobe", {1'b0, e_ws}, {1'b0, ws});
      chk("rd_en", {5'h00, e_re}, {5'h00, re});
      chk("irq_line", {7'h00, e_irq}, {7'h00, irq});
      chk("vector", e_data, data);
      chk("vector_oe", {7'h00, e_oe}, {7'h00, oe});
      chk("rx_mask", {7'h00, msk}, {7'h00, mskb});
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge i_clk);
    rst_b <= 1'b1;
    foreach (tbl[k]) begin
      i_cpu_bus_model.io_cycle(1'b1, tbl[k], 8'h00);
      i_cpu_bus_model.io_cycle(1'b0, tbl[k], 8'h00);
    end
    $display("test port_map done");
    rx <= 1'b1;
    i_cpu_bus_model.io_cycle(1'b1, 8'h62, 8'h10);
    repeat (3) @(posedge i_clk);
    i_cpu_bus_model.io_cycle(1'b1, 8'h62, 8'hEF);
    rx <= 1'b0;
    $display("test rx_mask done");
    for (int v = 1; v < 9; v++) begin
      {tx, jmp, vf, rx, kbd} <= (v == 8) ? 5'h18 : 5'(v);
      i_cpu_bus_model.int_ack(ok);
      chk("ack_taken", 8'h01, {7'h00, ok});
      // flags read between acknowledges; its read enable and all other outputs but o_serial_cmd_sel are checked
      i_cpu_bus_model.io_cycle(1'b0, 8'h42, 8'h00);
    end
    {tx, jmp, vf, rx, kbd} <= 5'h00;
    $display("test vectors done");
    rnd_on <= 1'b1;
    repeat (400) begin
      r = lfsr(r);
      op = r[1:0];
      r = lfsr(r);
      if (op[1]) i_cpu_bus_model.io_cycle(op[0], r, ~r);
      else if (op[0]) i_cpu_bus_model.int_ack(ok);
      else @(posedge i_clk);
    end
    rnd_on <= 1'b0;
    $display("test random done");
    rst_b <= 1'b0;
    repeat (3) @(posedge i_clk);
    rst_b <= 1'b1;
    i_cpu_bus_model.io_cycle(1'b1, 8'hE2, 8'h00);
    repeat (2) @(posedge i_clk);
    $display("test reset_again done");
    summarize();
  end
endmodule
